// file: inc/scm_pkg.sv
// Package for the system clock and operating mode controller
package scm_pkg;

  // APB register byte addresses
  localparam logic [11:0] CLK_CTRL_OFFSET = 12'h000;
  localparam logic [11:0] MODE_STAT_OFFSET = 12'h004;
  localparam logic [11:0] SLOW_ACK_OFFSET = 12'h008;

  // Field positions in clock_control_register
  localparam int SEL_LSB = 5;
  localparam int STABLE_BIT = 3;
  localparam int FAST_EN_BIT = 2;
  localparam int FAST_KEEP_BIT = 1;
  localparam int SLOW_KEEP_BIT = 0;

  // Field positions in the read-only status word
  localparam int STAT_MODE_LSB = 0;
  localparam int STAT_BUSY_BIT = 4;
  localparam int STAT_ACTIVE_LSB = 5;

  // Reset values
  localparam logic [2:0] SEL_RESET = 3'h7;
  localparam logic [2:0] SEL_SUB = 3'h7;
  localparam logic [31:0] APB_ZERO = 32'h0000_0000;

  // Switch timing: 4 system periods minimum before the new clock is trusted
  localparam int SWITCH_SYS_PERIODS = 4;
  // Fast oscillator settle time in ns and derived count at 25 MHz
  localparam int CLK_PERIOD_NS = 40;
  localparam int FAST_SETTLE_NS = 400;
  localparam int FAST_SETTLE_CYC = (FAST_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Operating modes
  typedef enum logic [2:0] {
    MODE_FAST,
    MODE_SLOW,
    MODE_SLEEP,
    MODE_IDLE_SLOW_ONLY,
    MODE_IDLE_BOTH_OSC,
    MODE_IDLE_FAST_ONLY
  } scm_mode_e;

  // APB request
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } scm_apb_req_s;

  // APB answer
  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } scm_apb_rsp_s;

  // Clock enables handed to the clock tree
  typedef struct packed {
    logic cpuRun;
    logic sysClkEn;
    logic sysTick;
    logic fastOscOn;
    logic fastClkEn;
    logic subClkEn;
    logic slowOscOn;
  } scm_gate_s;

endpackage : scm_pkg

// file: src/scm_clock_mode.sv
// System clock select, divider and operating mode control
// What this block does
// - System clock comes from fast branch or sub branch per select field.
// - Fast branch from fast RC oscillator, sub branch from slow RC oscillator.
// - FAST mode clocks CPU from fast clock divided by 1 to 64.
// - FAST mode: CPU runs, fast, sub and slow clocks all on.
// - SLOW mode at code 111: CPU runs on sub clock.
// - On sub clock, fast oscillator follows its enable bit.
// - Six modes: FAST, SLOW run the CPU; SLEEP and three IDLEs stop it.
// - Halt with both keep bits low enters SLEEP, stopping CPU and sub clock.
// - In SLEEP the slow oscillator runs only while watchdog is enabled.
// - Halt with fast keep low, slow keep high enters slow-only idle.
// - Halt with both keep bits high enters both-oscillator idle.
// - Halt with fast keep high, slow keep low enters fast-only idle.
// - Codes 000 to 110 give fast clock /1../64, 111 gives sub clock.
// - Enabling fast oscillator clears stable flag, then sets it once stable.
// - A clock switch completes after 4 periods of the old system clock alone.
// Bus side: every APB access gets one wait state.
// pready, pslverr and prdata stand for one cycle only.
// Offset 0x000 holds the control word, 0x004 a read-only status word.
// Other offsets, or a status write, answer pslverr and change nothing.
// CPU side: haltReq is a one-cycle pulse honoured only in FAST or SLOW.
// The new mode and its gates appear one cycle after the halt pulse.
// wakeReq returns to the run mode of the active select, one cycle later.
// Oscillator side: both ticks are single-cycle enables already in clk domain.
// No synchroniser here; a wrapper fed by raw oscillator edges must add one.
// Clock switch: a new select applies after four ticks of the old branch,
// so the CPU never sees a runt period while the source changes.
// The target branch gets no extra wait of its own.
// Software still owes the settle time before it relies on the new rate.
// Limitation: the switch counts ticks of a branch that SLEEP may gate off,
// so a switch written just before a halt can stay pending until wake-up.
// FAST or SLOW is reported one cycle after the switch completes.
// Reset leaves SLOW mode on the sub clock with the fast oscillator off.
// The CPU keeps running straight through reset release.
// Idle system branch: kept only while the branch enable behind the active select
// (subClkEn or fastOscOn) stays on; otherwise it is gated off with the CPU.
// Stable flag restarts from zero whenever the fast oscillator is enabled.
`timescale 1ns/1ns
`default_nettype none

module scm_clock_mode
  import scm_pkg::*;
#(
  parameter int SETTLE_CYCLES = FAST_SETTLE_CYC,
  parameter int DIV_WIDTH = 6
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // APB slave
  input wire scm_pkg::scm_apb_req_s apbReq,
  output scm_pkg::scm_apb_rsp_s apbRsp,
  // CPU events and watchdog state
  input wire logic haltReq,
  input wire logic wakeReq,
  input wire logic watchdogEnable,
  // Oscillator ticks, already in clk domain
  input wire logic fastOscTick,
  input wire logic slowOscTick,
  // Clock tree enables and mode
  output scm_pkg::scm_gate_s gates,
  output scm_pkg::scm_mode_e mode,
  output logic switchBusy
);
  import scm_pkg::*;

  // Elaboration check: divider must reach /64
  if (DIV_WIDTH < 6) begin : g_bad_div
    $error("DIV_WIDTH must be at least 6");
  end
  if (SETTLE_CYCLES < 1) begin : g_bad_settle
    $error("SETTLE_CYCLES must be at least 1");
  end
  // The divide mask is built in 64 bits
  if (DIV_WIDTH > 63) begin : g_wide_div
    $error("DIV_WIDTH must be below 64");
  end
  // The switch counter is three bits wide
  if (SWITCH_SYS_PERIODS < 1 || SWITCH_SYS_PERIODS > 7) begin : g_bad_switch
    $error("SWITCH_SYS_PERIODS must lie between 1 and 7");
  end

  // Settle counter just wide enough to reach SETTLE_CYCLES
  localparam int SW = $clog2(SETTLE_CYCLES + 1);

  // Whole state of the block
  typedef struct packed {
    // Software visible control bits
    logic [2:0] sel;
    logic fastEn;
    logic fastKeep;
    logic slowKeep;
    // Oscillator status
    logic stable;
    logic [SW-1:0] settleCnt;
    // Divider and clock switch
    logic [DIV_WIDTH-1:0] divCnt;
    logic [2:0] swCnt;
    logic [2:0] activeSel;
    // Registered outputs
    scm_mode_e mode;
    scm_gate_s gates;
    scm_apb_rsp_s rsp;
  } scm_state_s;

  scm_state_s st_q;
  scm_state_s st_d;

  // Helpers filled inside the next-state process
  logic apbAccess;
  logic [DIV_WIDTH-1:0] divMask;
  logic fastTickDiv;
  logic runMode;
  logic idleSysOn;
  logic sysTickRaw;

  // Combinational next state
  always_comb begin
    st_d = st_q;
    apbAccess = apbReq.psel && apbReq.penable;
    st_d.rsp.pready = 1'b0;
    st_d.rsp.pslverr = 1'b0;

    // Divide ratio 2^activeSel; code 111 leaves the fast branch
    divMask = DIV_WIDTH'((64'h1 << st_q.activeSel) - 64'h1);
    fastTickDiv = fastOscTick && ((st_q.divCnt & divMask) == '0);
    // Divider runs freely; only its low bits set the ratio
    if (fastOscTick) begin
      st_d.divCnt = st_q.divCnt + 1'b1;
    end

    // Stable flag: cleared while off, counts settle time once enabled
    // A disabled oscillator is never reported as stable
    if (!st_q.fastEn) begin
      st_d.stable = 1'b0;
      st_d.settleCnt = '0;
    end else if (!st_q.stable) begin
      if (st_q.settleCnt == SW'(SETTLE_CYCLES)) begin
        st_d.stable = 1'b1;
      end else begin
        st_d.settleCnt = st_q.settleCnt + 1'b1;
      end
    end

    // APB access: single-cycle answer in the access phase
    st_d.rsp.prdata = APB_ZERO;
    if (apbAccess && !st_q.rsp.pready) begin
      st_d.rsp.pready = 1'b1;
      unique case (apbReq.paddr)
        CLK_CTRL_OFFSET: begin
          // Write lands at the edge that takes the access
          if (apbReq.pwrite) begin
            st_d.sel = apbReq.pwdata[SEL_LSB +: 3];
            st_d.fastEn = apbReq.pwdata[FAST_EN_BIT];
            st_d.fastKeep = apbReq.pwdata[FAST_KEEP_BIT];
            st_d.slowKeep = apbReq.pwdata[SLOW_KEEP_BIT];
            if (apbReq.pwdata[FAST_EN_BIT] && !st_q.fastEn) begin
              st_d.stable = 1'b0;
              st_d.settleCnt = '0;
            end
            // Rewriting the same select starts no switch
            if (apbReq.pwdata[SEL_LSB +: 3] != st_q.sel) begin
              st_d.swCnt = 3'(SWITCH_SYS_PERIODS);
            end
          end
          // Read data shows the state before this access
          st_d.rsp.prdata[SEL_LSB +: 3] = st_q.sel;
          st_d.rsp.prdata[STABLE_BIT] = st_q.stable;
          st_d.rsp.prdata[FAST_EN_BIT] = st_q.fastEn;
          st_d.rsp.prdata[FAST_KEEP_BIT] = st_q.fastKeep;
          st_d.rsp.prdata[SLOW_KEEP_BIT] = st_q.slowKeep;
        end
        // Status word is read-only; a write is refused
        MODE_STAT_OFFSET: begin
          st_d.rsp.prdata[STAT_MODE_LSB +: 3] = st_q.mode;
          st_d.rsp.prdata[STAT_BUSY_BIT] = st_q.swCnt != '0;
          st_d.rsp.prdata[STAT_ACTIVE_LSB +: 3] = st_q.activeSel;
          st_d.rsp.pslverr = apbReq.pwrite;
        end
        // Unmapped offsets answer an error and change nothing
        default: begin
          st_d.rsp.pslverr = 1'b1;
        end
      endcase
    end

    // System tick before idle gating
    sysTickRaw = (st_q.activeSel == SEL_SUB) ? slowOscTick : fastTickDiv;

    // Switch completes after 4 ticks of the current system clock
    if (st_q.swCnt != '0 && sysTickRaw) begin
      st_d.swCnt = st_q.swCnt - 1'b1;
      // The last tick clears busy and moves the active select together
      if (st_q.swCnt == 3'h1) begin
        st_d.activeSel = st_q.sel;
      end
    end

    // Mode sequencing
    unique case (st_q.mode)
      MODE_FAST, MODE_SLOW: begin
        // A halt picks the low-power mode from the two keep bits
        if (haltReq) begin
          unique case ({st_q.fastKeep, st_q.slowKeep})
            2'b00: st_d.mode = MODE_SLEEP;
            2'b01: st_d.mode = MODE_IDLE_SLOW_ONLY;
            2'b11: st_d.mode = MODE_IDLE_BOTH_OSC;
            2'b10: st_d.mode = MODE_IDLE_FAST_ONLY;
          endcase
        end else begin
          st_d.mode = (st_q.activeSel == SEL_SUB) ? MODE_SLOW : MODE_FAST;
        end
      end
      MODE_SLEEP, MODE_IDLE_SLOW_ONLY, MODE_IDLE_BOTH_OSC, MODE_IDLE_FAST_ONLY: begin
        // Wake-up returns to the run mode of the active select
        if (wakeReq) begin
          st_d.mode = (st_q.activeSel == SEL_SUB) ? MODE_SLOW : MODE_FAST;
        end
      end
      // Unused codes recover to the reset mode
      default: begin
        st_d.mode = MODE_SLOW;
      end
    endcase

    // Gates for the mode being entered
    runMode = st_d.mode == MODE_FAST || st_d.mode == MODE_SLOW;
    st_d.gates.cpuRun = runMode;
    unique case (st_d.mode)
      // Running on the fast branch: everything stays on
      MODE_FAST: begin
        st_d.gates.fastOscOn = 1'b1;
        st_d.gates.subClkEn = 1'b1;
        st_d.gates.slowOscOn = 1'b1;
      end
      // Fast oscillator may keep running for peripherals
      MODE_SLOW: begin
        st_d.gates.fastOscOn = st_d.fastEn;
        st_d.gates.subClkEn = 1'b1;
        st_d.gates.slowOscOn = 1'b1;
      end
      // Deepest mode; only the watchdog may hold the slow oscillator
      MODE_SLEEP: begin
        st_d.gates.fastOscOn = 1'b0;
        st_d.gates.subClkEn = 1'b0;
        st_d.gates.slowOscOn = watchdogEnable;
      end
      // Slow oscillator feeds peripherals, fast one stops
      MODE_IDLE_SLOW_ONLY: begin
        st_d.gates.fastOscOn = 1'b0;
        st_d.gates.subClkEn = 1'b1;
        st_d.gates.slowOscOn = 1'b1;
      end
      // Both oscillators keep peripherals alive
      MODE_IDLE_BOTH_OSC: begin
        st_d.gates.fastOscOn = 1'b1;
        st_d.gates.subClkEn = 1'b1;
        st_d.gates.slowOscOn = 1'b1;
      end
      // Fast-only idle; sub clock to peripherals stops
      default: begin
        st_d.gates.fastOscOn = 1'b1;
        st_d.gates.subClkEn = 1'b0;
        st_d.gates.slowOscOn = 1'b1;
      end
    endcase
    // Fast branch enable simply mirrors its oscillator
    st_d.gates.fastClkEn = st_d.gates.fastOscOn;

    // Idle keeps system branch only if its source still runs
    idleSysOn = (st_d.activeSel == SEL_SUB) ? st_d.gates.subClkEn : st_d.gates.fastOscOn;
    st_d.gates.sysClkEn = runMode || idleSysOn;
    // Tick qualified by the enable in force, not the one being set
    st_d.gates.sysTick = sysTickRaw && st_q.gates.sysClkEn;
  end

  // State register with synchronous reset
  always_ff @(posedge clk) begin
    if (rst) begin
      // SLOW mode on the sub clock, fast oscillator off
      st_q <= '0;
      st_q.sel <= SEL_RESET;
      st_q.activeSel <= SEL_RESET;
      st_q.mode <= MODE_SLOW;
      st_q.gates.cpuRun <= 1'b1;
      st_q.gates.sysClkEn <= 1'b1;
      st_q.gates.subClkEn <= 1'b1;
      st_q.gates.slowOscOn <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs straight from state flops
  assign apbRsp = st_q.rsp;
  assign gates = st_q.gates;
  assign mode = st_q.mode;
  assign switchBusy = st_q.swCnt != '0;

endmodule : scm_clock_mode

`default_nettype wire

// file: sim/scm_checker.sv
// Concurrent checks on the ports of the clock and mode controller
`timescale 1ns/1ns
`default_nettype none
module scm_checker
  import scm_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Watched ports
  input wire scm_pkg::scm_apb_req_s apbReq,
  input wire scm_pkg::scm_apb_rsp_s apbRsp,
  input wire logic haltReq,
  input wire logic watchdogEnable,
  input wire scm_pkg::scm_gate_s gates,
  input wire scm_pkg::scm_mode_e mode
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic [1:0] keepQ;
  scm_mode_e haltMode;
  // Keep bits shadowed from completed writes; the register itself is out of sight
  always_ff @(posedge clk) begin
    if (rst)
      keepQ <= 2'h0;
    else if (apbReq.psel && apbReq.penable && apbReq.pwrite && apbRsp.pready
             && apbReq.paddr == CLK_CTRL_OFFSET)
      keepQ <= apbReq.pwdata[1:0];
  end
  // Mode a halt must lead to
  assign haltMode = keepQ == 2'h0 ? MODE_SLEEP : keepQ == 2'h1 ? MODE_IDLE_SLOW_ONLY :
                    keepQ == 2'h2 ? MODE_IDLE_FAST_ONLY : MODE_IDLE_BOTH_OSC;
  // Bus and halt steps
  sequence s_setup; apbReq.psel && !apbReq.penable; endsequence
  sequence s_access; apbReq.psel && apbReq.penable; endsequence
  sequence s_halt; haltReq && (mode == MODE_FAST || mode == MODE_SLOW); endsequence
  a_apb_wait_state: assert property (s_setup ##1 s_access |=> apbRsp.pready)
    else $error("pready not one cycle after access");
  a_ready_one_cycle: assert property (apbRsp.pready |=> !apbRsp.pready)
    else $error("pready held too long");
  a_halt_entry: assert property (s_halt |-> ##[1:2] mode == haltMode)
    else $error("halt led to wrong mode");
  a_fast_all_on: assert property (mode == MODE_FAST |-> gates.cpuRun && gates.fastClkEn
    && gates.subClkEn && gates.slowOscOn)
    else $error("fast mode clock missing");
  a_slow_cpu_run: assert property (mode == MODE_SLOW |-> gates.cpuRun && gates.subClkEn)
    else $error("slow mode clock missing");
  a_sleep_gates: assert property (mode == MODE_SLEEP |-> !gates.cpuRun && !gates.subClkEn)
    else $error("sleep left a clock on");
  a_sleep_watchdog: assert property (mode == MODE_SLEEP && $stable(watchdogEnable)
    |-> gates.slowOscOn == watchdogEnable)
    else $error("slow oscillator wrong in sleep");
  a_idle_cpu_off: assert property (mode inside {MODE_IDLE_SLOW_ONLY, MODE_IDLE_BOTH_OSC,
    MODE_IDLE_FAST_ONLY} |-> !gates.cpuRun)
    else $error("cpu runs in idle");
  a_idle_slow_only: assert property (mode == MODE_IDLE_SLOW_ONLY |-> gates.slowOscOn
    && !gates.fastClkEn)
    else $error("slow-only idle gates wrong");
  a_idle_both_osc: assert property (mode == MODE_IDLE_BOTH_OSC |-> gates.fastOscOn
    && gates.slowOscOn)
    else $error("both-oscillator idle gates wrong");
  a_idle_fast_only: assert property (mode == MODE_IDLE_FAST_ONLY |-> gates.fastOscOn
    && !gates.subClkEn)
    else $error("fast-only idle gates wrong");
endmodule : scm_checker
bind scm_clock_mode scm_checker scm_checker_i (.clk, .rst, .apbReq, .apbRsp, .haltReq,
  .watchdogEnable, .gates, .mode);
`default_nettype wire

// file: sim/scm_osc_model.sv
// Tick model standing in for the fast and slow RC oscillators
`timescale 1ns/1ns
`default_nettype none
module scm_osc_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Run requests and ticks
  input wire logic fastOn,
  input wire logic slowOn,
  output logic fastTick,
  output logic slowTick
);
  logic [2:0] cntQ;
  // Free count; fast ticks every 2 cycles, slow every 8
  always_ff @(posedge clk) begin
    cntQ <= rst ? 3'h0 : cntQ + 3'h1;
  end
  // A stopped oscillator gives no ticks at all
  assign fastTick = fastOn && cntQ[0];
  assign slowTick = slowOn && (cntQ == 3'h7);
endmodule : scm_osc_model
`default_nettype wire

// file: sim/system_clock_mode_control_tb_top.sv
// Self-checking bench for the clock and mode controller
`timescale 1ns/1ns
`default_nettype none
module system_clock_mode_control_tb_top;
  import scm_pkg::*;
  logic clk = 0, rst = 1, haltReq = 0, wakeReq = 0, watchdogEnable = 0, fTick, sTick, switchBusy;
  scm_apb_req_s req = '0;
  scm_apb_rsp_s apbRsp;
  scm_gate_s gates;
  scm_mode_e mode;
  int numErrors = 0, cmpCount = 0;
  scm_clock_mode #(.SETTLE_CYCLES(8)) scm_clock_mode_i (.clk(clk), .rst(rst), .apbReq(req),
    .apbRsp(apbRsp), .haltReq(haltReq), .wakeReq(wakeReq), .watchdogEnable(watchdogEnable),
    .fastOscTick(fTick), .slowOscTick(sTick), .gates(gates), .mode(mode),
    .switchBusy(switchBusy));
  scm_osc_model scm_osc_model_i (.clk(clk), .rst(rst), .fastOn(gates.fastOscOn),
    .slowOn(gates.slowOscOn), .fastTick(fTick), .slowTick(sTick));
  // 25 MHz clock
  initial begin
    forever #20 clk = ~clk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmpCount++;
    if (seen !== exp) begin
      numErrors++;
      $display("[FAIL] %0t saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  // One APB transfer; waits for pready however long it takes
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge clk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge clk);
    req.penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (apbRsp.pready !== 1'b1);
    r = apbRsp.prdata;
    e = apbRsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask : apb
  // Write control, let a pending switch finish and the run mode follow it
  task automatic ctrl(input logic [2:0] sel, input logic [4:0] low);
    logic [31:0] r;
    logic e;
    int n;
    n = 0;
    apb(1, CLK_CTRL_OFFSET, {24'h0000_00, sel, low}, r, e);
    @(posedge clk);
    while (switchBusy !== 1'b0 && n < 2000) begin
      @(posedge clk);
      n++;
    end
    @(posedge clk);
    check(32'(switchBusy), 0);
  endtask : ctrl
  // Reset values, unmapped and read-only places
  task automatic t_regs;
    logic [31:0] r;
    logic e;
    check(32'(mode), 32'(MODE_SLOW));
    apb(0, CLK_CTRL_OFFSET, 0, r, e);
    check(r, {24'h0000_00, SEL_RESET, 5'h00});
    apb(0, 12'h00C, 0, r, e);
    check(32'(e), 1);
    apb(1, MODE_STAT_OFFSET, 32'h0000_00FF, r, e);
    check(32'(e), 1);
  endtask : t_regs
  // Every keep combination on sub and fast select, sleep with and without watchdog
  task automatic t_halt;
    scm_mode_e exp[5] = '{MODE_SLEEP, MODE_IDLE_SLOW_ONLY, MODE_IDLE_FAST_ONLY,
                          MODE_IDLE_BOTH_OSC, MODE_SLEEP};
    int j;
    logic sysExp;
    for (int i = 0; i < 10; i++) begin
      j = i % 5;
      sysExp = (i < 5) ? (j == 1 || j == 3) : (j == 2 || j == 3);
      ctrl((i < 5) ? SEL_SUB : 3'h0, {3'h0, 2'(j)});
      watchdogEnable <= (j != 4);
      haltReq <= 1'b1;
      @(posedge clk);
      haltReq <= 1'b0;
      repeat (3) @(posedge clk);
      check(32'(mode), 32'(exp[j]));
      check(32'(gates.cpuRun), 0);
      check(32'(gates.sysClkEn), 32'(sysExp));
      if (j == 0 || j == 4) check(32'(gates.slowOscOn), 32'(j == 0));
      wakeReq <= 1'b1;
      @(posedge clk);
      wakeReq <= 1'b0;
      repeat (3) @(posedge clk);
      check(32'(mode), 32'((i < 5) ? MODE_SLOW : MODE_FAST));
    end
  endtask : t_halt
  // Stable flag, every divide ratio, back to sub clock
  task automatic t_divide;
    logic [31:0] r;
    logic e;
    int c;
    ctrl(SEL_SUB, 5'h00);
    ctrl(SEL_SUB, 5'h04);
    apb(0, CLK_CTRL_OFFSET, 0, r, e);
    check(32'(r[STABLE_BIT]), 0);
    repeat (12) @(posedge clk);
    apb(0, CLK_CTRL_OFFSET, 0, r, e);
    check(32'(r[STABLE_BIT]), 1);
    for (int k = 0; k < 7; k++) begin
      ctrl(3'(k), 5'h04);
      check(32'(mode), 32'(MODE_FAST));
      c = 0;
      while (gates.sysTick !== 1'b1 && c < 500) begin
        @(posedge clk);
        c++;
      end
      c = 0;
      do begin
        @(posedge clk);
        c++;
      end while (gates.sysTick !== 1'b1 && c < 500);
      check(32'(c), 32'(2 << k));
    end
    ctrl(SEL_SUB, 5'h04);
    check(32'(mode), 32'(MODE_SLOW));
    check(32'(gates.fastOscOn), 1);
    ctrl(SEL_SUB, 5'h00);
    repeat (3) @(posedge clk);
    check(32'(gates.fastOscOn), 0);
  endtask : t_divide
  task automatic end_of_test;
    $display("Comparisons %0d, mismatches %0d", cmpCount, numErrors);
    if (numErrors == 0 && cmpCount > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : end_of_test
  // Main sequence: two reset cycles, then the scenarios
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_halt();
    t_divide();
    end_of_test();
  end
  // Hang guard, well beyond the few thousand cycles needed
  initial begin
    #400000;
    numErrors++;
    end_of_test();
  end
endmodule : system_clock_mode_control_tb_top
`default_nettype wire
